/* pmwr_pkg.sv */
// package: register map, field layout and encodings of the power mode / wakeup / reset unit
`default_nettype none
package pmwr_pkg;
	// register byte addresses (printed offsets are not all multiples of four: index * 4)
	localparam logic [7:0]  IDX_WAKEUP_SOURCE_CONFIG   = 8'hA5;
	localparam logic [7:0]  IDX_OPERATIONAL_MODE_CTRL  = 8'hAE;
	localparam logic [7:0]  IDX_RESET_CAUSE            = 8'hB1;
	localparam logic [7:0]  IDX_PIN_WAKEUP_ENABLE_HIGH = 8'hCE;
	localparam logic [7:0]  IDX_PIN_WAKEUP_ENABLE_LOW  = 8'hCF;
	localparam logic [7:0]  IDX_WAKE_STATUS            = 8'hD0;
	localparam logic [11:0] ADDR_WAKEUP_SOURCE_CONFIG  = {2'h0, IDX_WAKEUP_SOURCE_CONFIG, 2'h0};
	localparam logic [11:0] ADDR_OPERATIONAL_MODE_CTRL = {2'h0, IDX_OPERATIONAL_MODE_CTRL, 2'h0};
	localparam logic [11:0] ADDR_RESET_CAUSE           = {2'h0, IDX_RESET_CAUSE, 2'h0};
	localparam logic [11:0] ADDR_PIN_WAKEUP_ENABLE_HIGH = {2'h0, IDX_PIN_WAKEUP_ENABLE_HIGH, 2'h0};
	localparam logic [11:0] ADDR_PIN_WAKEUP_ENABLE_LOW = {2'h0, IDX_PIN_WAKEUP_ENABLE_LOW, 2'h0};
	localparam logic [11:0] ADDR_WAKE_STATUS           = {2'h0, IDX_WAKE_STATUS, 2'h0};
	// reset values
	localparam logic [7:0]  RST_WAKEUP_SOURCE_CONFIG   = 8'h00;
	localparam logic [7:0]  RST_OPERATIONAL_MODE_CTRL  = 8'h00;
	localparam logic [7:0]  RST_PIN_WAKEUP_ENABLE      = 8'h00;
	// operational mode control fields
	localparam int          OPM_POLARITY_BIT  = 2;
	localparam int          OPM_LATCH_LOCK_BIT = 1;
	localparam int          OPM_WDOG_RESET_BIT = 0;
	localparam logic [7:0]  OPM_WRITABLE_MASK = 8'h07;
	// reset cause bits
	localparam int          CAUSE_PIN_BIT   = 0;
	localparam int          CAUSE_WDOG_BIT  = 1;
	localparam int          CAUSE_DEBUG_BIT = 2;
	// wakeup source config field positions (low bit of each 2-bit field)
	localparam int          WUC_RADIO_LSB = 6;
	localparam int          WUC_TICK_LSB  = 4;
	localparam int          WUC_PIN_LSB   = 2;
	localparam int          WUC_MISC_LSB  = 0;
	// wakeup field encodings
	localparam logic [1:0]  WUC_IF_ENABLED = 2'h0;
	localparam logic [1:0]  WUC_RESERVED   = 2'h1;
	localparam logic [1:0]  WUC_ALWAYS     = 2'h2;
	localparam logic [1:0]  WUC_IGNORE     = 2'h3;
	// interrupt enable positions in interrupt_enable_group_one
	localparam int          IEN_RADIO_BIT = 1;
	localparam int          IEN_PIN_BIT   = 3;
	localparam int          IEN_MISC_BIT  = 4;
	localparam int          IEN_TICK_BIT  = 5;
	// package variants
	localparam logic [1:0]  PKG_LARGE = 2'h0;
	localparam logic [1:0]  PKG_MID   = 2'h1;
	localparam logic [1:0]  PKG_SMALL = 2'h2;
	// power-down mode codes as presented by the power-down command logic
	localparam logic [2:0]  PD_NONE      = 3'h0;
	localparam logic [2:0]  PD_DEEP      = 3'h1;
	localparam logic [2:0]  PD_MEM_OFF   = 3'h2;
	localparam logic [2:0]  PD_MEM_ON    = 3'h3;
	localparam logic [2:0]  PD_REG_RET   = 3'h4;
	localparam logic [2:0]  PD_STANDBY   = 3'h7;

	// reset requests from the four sources
	typedef struct packed {
		logic generator;
		logic pin;
		logic watchdog;
		logic debugger;
	} pmwr_rst_req_t;

	// raw event lines feeding the standby wakeup decision
	typedef struct packed {
		logic radio;
		logic tick;
		logic pin;
		logic xosc_ready;
		logic adc_done;
		logic rng_ready;
	} pmwr_events_t;
endpackage : pmwr_pkg
`default_nettype wire

/* pmwr_ctrl.sv */
// power mode control, reset cause record and wakeup source selection with APB access
// Notes on behaviour
// - polarity bit makes subset of pins active-low
// - lock bit freezes retention latches, else transparent
// - watchdog runs unless deep sleep, bit clear
// - bit set resets watchdog in retention modes
// - all four reset sources start same sequence
// - cause bits: pin, watchdog, debugger
// - any write to reset cause clears all cause bits; a write in a cause_capture cycle clears nothing
// - causes accumulate; generator reset or write clears
// - radio interrupt wakeup field bits 7:6
// - tick wakeup field bits 5:4
// - pin interrupt wakeup field bits 3:2
// - miscellaneous interrupt wakeup field bits 1:0
// - interrupt wakeup selections apply in standby
// - misc interrupt: crystal, ADC or random ready
// - two pin enable registers, reset zero
// - largest package maps port 2, 3, 1.7
// - mid and small package pin mapping
// - only marked pins follow polarity select
// - enabled spi slave chip-select wakes active-low
`timescale 1ns/10ps
`default_nettype none
module pmwr_ctrl (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic                         pready,
	output logic [31:0]                  prdata,
	output logic                         pslverr,
	input  wire logic [1:0]              package_sel,
	input  wire pmwr_pkg::pmwr_rst_req_t reset_req,
	input  wire logic                    cause_capture,
	input  wire logic [2:0]              power_down_mode,
	input  wire logic                    watchdog_enabled,
	input  wire logic [7:0]              interrupt_enable_group_one,
	input  wire pmwr_pkg::pmwr_events_t  events,
	input  wire logic [7:0]              port0_pins,
	input  wire logic [7:0]              port1_pins,
	input  wire logic [7:0]              port2_pins,
	input  wire logic [7:0]              port3_pins,
	input  wire logic                    spi_slave_enable,
	input  wire logic                    slave_chip_select_n,
	input  wire logic [7:0]              retention_setup_in,
	output logic [7:0]                   retention_setup_out,
	output logic                         system_reset_req,
	output logic                         watchdog_hold_reset,
	output logic                         watchdog_run,
	output logic                         pin_wakeup_interrupt,
	output logic                         miscellaneous_interrupt,
	output logic                         standby_wakeup
);
	logic [7:0]  wakeup_source_config_ff;
	logic [7:0]  operational_mode_control_ff;
	logic [2:0]  reset_cause_ff;
	logic [7:0]  pin_wakeup_enable_high_ff;
	logic [7:0]  pin_wakeup_enable_low_ff;
	logic [7:0]  retention_setup_ff;
	logic [3:0]  wake_status_ff;
	logic [31:0] prdata_ff;
	logic        pslverr_ff;
	logic        pready_ff;
	logic        sys_reset_ff;
	logic        wdog_hold_ff;
	logic        wdog_run_ff;
	logic        pin_irq_ff;
	logic        misc_irq_ff;
	logic        wake_ff;
	logic [32:0] pin_meta_ff;
	logic [32:0] pin_sync_ff;
	logic        mapped;
	logic        wr_access;
	logic [7:0]  map_low_mask;
	logic [7:0]  map_high_mask;
	logic [7:0]  pol_low_mask;
	logic [7:0]  pol_high_mask;
	logic [7:0]  src_low;
	logic [7:0]  src_high;
	logic [7:0]  act_low;
	logic [7:0]  act_high;
	logic        csn_wake;
	logic        nxt_pin_irq;
	logic        nxt_misc_irq;
	logic [3:0]  nxt_wake_src;
	logic [31:0] nxt_prdata;

	// APB answers in the access phase cycle itself; pready is held high after reset
	assign pready    = pready_ff;
	assign prdata    = prdata_ff;
	assign pslverr   = pslverr_ff;
	assign wr_access = psel && penable && pwrite;

	always_comb
	begin
		mapped = 1'b1;
		case (paddr)
			pmwr_pkg::ADDR_WAKEUP_SOURCE_CONFIG:   nxt_prdata = {24'h0, wakeup_source_config_ff};
			pmwr_pkg::ADDR_OPERATIONAL_MODE_CTRL:  nxt_prdata = {24'h0, operational_mode_control_ff};
			pmwr_pkg::ADDR_RESET_CAUSE:            nxt_prdata = {29'h0, reset_cause_ff};
			pmwr_pkg::ADDR_PIN_WAKEUP_ENABLE_HIGH:
				nxt_prdata = {24'h0, pin_wakeup_enable_high_ff & map_high_mask};
			pmwr_pkg::ADDR_PIN_WAKEUP_ENABLE_LOW:
				nxt_prdata = {24'h0, pin_wakeup_enable_low_ff & map_low_mask};
			pmwr_pkg::ADDR_WAKE_STATUS:            nxt_prdata = {28'h0, wake_status_ff};
			default:
			begin
				nxt_prdata = 32'h0;
				mapped     = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h0;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			pready_ff  <= 1'b1;
			pslverr_ff <= psel && !penable && !mapped;
			if (psel && !penable && !pwrite)
				prdata_ff <= nxt_prdata;
		end
	end

	// writable registers; upper mode bits are kept zero whatever software sends
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wakeup_source_config_ff     <= pmwr_pkg::RST_WAKEUP_SOURCE_CONFIG;
			operational_mode_control_ff <= pmwr_pkg::RST_OPERATIONAL_MODE_CTRL;
			pin_wakeup_enable_high_ff   <= pmwr_pkg::RST_PIN_WAKEUP_ENABLE;
			pin_wakeup_enable_low_ff    <= pmwr_pkg::RST_PIN_WAKEUP_ENABLE;
		end
		else if (wr_access)
		begin
			case (paddr)
				pmwr_pkg::ADDR_WAKEUP_SOURCE_CONFIG:
					wakeup_source_config_ff <= pwdata[7:0];
				pmwr_pkg::ADDR_OPERATIONAL_MODE_CTRL:
					operational_mode_control_ff <= pwdata[7:0] & pmwr_pkg::OPM_WRITABLE_MASK;
				pmwr_pkg::ADDR_PIN_WAKEUP_ENABLE_HIGH:
					pin_wakeup_enable_high_ff <= pwdata[7:0];
				pmwr_pkg::ADDR_PIN_WAKEUP_ENABLE_LOW:
					pin_wakeup_enable_low_ff <= pwdata[7:0];
				default:
					pin_wakeup_enable_low_ff <= pin_wakeup_enable_low_ff;
			endcase
		end
	end

	// reset cause: cleared on apb reset (the generator's) and by writes, except in a cause_capture cycle; other causes OR in
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			reset_cause_ff <= 3'h0;
		else if (reset_req.generator)
			reset_cause_ff <= 3'h0;
		else if (cause_capture)
			reset_cause_ff <= reset_cause_ff | {reset_req.debugger, reset_req.watchdog,
				reset_req.pin};
		else if (wr_access && paddr == pmwr_pkg::ADDR_RESET_CAUSE)
			reset_cause_ff <= 3'h0;
	end

	// one common reset request whatever its source
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sys_reset_ff <= 1'b0;
		else
			sys_reset_ff <= |reset_req;
	end
	assign system_reset_req = sys_reset_ff;

	// retention latches: transparent while unlocked, frozen while locked
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			retention_setup_ff <= 8'h00;
		else if (!operational_mode_control_ff[pmwr_pkg::OPM_LATCH_LOCK_BIT])
			retention_setup_ff <= retention_setup_in;
	end
	assign retention_setup_out = retention_setup_ff;

	// watchdog control by power-down mode
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wdog_hold_ff <= 1'b0;
			wdog_run_ff  <= 1'b0;
		end
		else
		begin
			wdog_hold_ff <= operational_mode_control_ff[pmwr_pkg::OPM_WDOG_RESET_BIT] &&
				(power_down_mode == pmwr_pkg::PD_MEM_OFF ||
				 power_down_mode == pmwr_pkg::PD_MEM_ON ||
				 power_down_mode == pmwr_pkg::PD_REG_RET);
			wdog_run_ff <= watchdog_enabled && power_down_mode != pmwr_pkg::PD_DEEP &&
				!(operational_mode_control_ff[pmwr_pkg::OPM_WDOG_RESET_BIT] &&
				  (power_down_mode == pmwr_pkg::PD_MEM_OFF ||
				   power_down_mode == pmwr_pkg::PD_MEM_ON ||
				   power_down_mode == pmwr_pkg::PD_REG_RET));
		end
	end
	assign watchdog_hold_reset = wdog_hold_ff;
	assign watchdog_run        = wdog_run_ff;

	// pins and chip-select come from outside: two flops before use
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_meta_ff <= {1'b1, 32'h0};
			pin_sync_ff <= {1'b1, 32'h0};
		end
		else
		begin
			pin_meta_ff <= {slave_chip_select_n, port3_pins, port2_pins, port1_pins, port0_pins};
			pin_sync_ff <= pin_meta_ff;
		end
	end

	// package map: mask of bits that own a pin and of those with selectable polarity
	always_comb
	begin
		case (package_sel)
			pmwr_pkg::PKG_LARGE:
			begin
				src_low       = pin_sync_ff[23:16];
				src_high      = {pin_sync_ff[15], pin_sync_ff[30:24]};
				map_low_mask  = 8'hFF;
				map_high_mask = 8'hFF;
				pol_low_mask  = 8'h44;
				pol_high_mask = 8'h00;
			end
			pmwr_pkg::PKG_MID:
			begin
				src_low       = pin_sync_ff[7:0];
				src_high      = {1'b0, pin_sync_ff[14:8]};
				map_low_mask  = 8'hFF;
				map_high_mask = 8'h7F;
				pol_low_mask  = 8'h40;
				pol_high_mask = 8'h14;
			end
			pmwr_pkg::PKG_SMALL:
			begin
				src_low       = {1'b0, pin_sync_ff[6:0]};
				src_high      = 8'h00;
				map_low_mask  = 8'h7F;
				map_high_mask = 8'h00;
				pol_low_mask  = 8'h40;
				pol_high_mask = 8'h00;
			end
			default:
			begin
				src_low       = 8'h00;
				src_high      = 8'h00;
				map_low_mask  = 8'h00;
				map_high_mask = 8'h00;
				pol_low_mask  = 8'h00;
				pol_high_mask = 8'h00;
			end
		endcase
	end

	// inversion only on the selectable subset, and only with the polarity bit set
	always_comb
	begin
		if (operational_mode_control_ff[pmwr_pkg::OPM_POLARITY_BIT])
		begin
			act_low  = src_low ^ pol_low_mask;
			act_high = src_high ^ pol_high_mask;
		end
		else
		begin
			act_low  = src_low;
			act_high = src_high;
		end
		csn_wake    = spi_slave_enable && !pin_sync_ff[32];
		nxt_pin_irq = |(act_low & pin_wakeup_enable_low_ff & map_low_mask) ||
			|(act_high & pin_wakeup_enable_high_ff & map_high_mask) || csn_wake;
		nxt_misc_irq = events.xosc_ready || events.adc_done || events.rng_ready;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_irq_ff  <= 1'b0;
			misc_irq_ff <= 1'b0;
		end
		else
		begin
			pin_irq_ff  <= nxt_pin_irq;
			misc_irq_ff <= nxt_misc_irq;
		end
	end
	assign pin_wakeup_interrupt    = pin_irq_ff;
	assign miscellaneous_interrupt = misc_irq_ff;

	// per-source wakeup decision; reserved code wakes nothing
	function automatic logic wake_sel(input logic [1:0] cfg, input logic ev, input logic ien);
		case (cfg)
			pmwr_pkg::WUC_IF_ENABLED: wake_sel = ev && ien;
			pmwr_pkg::WUC_ALWAYS:     wake_sel = ev;
			pmwr_pkg::WUC_IGNORE:     wake_sel = 1'b0;
			default:                  wake_sel = 1'b0;
		endcase
	endfunction : wake_sel

	always_comb
	begin
		nxt_wake_src[3] = wake_sel(wakeup_source_config_ff[pmwr_pkg::WUC_RADIO_LSB +: 2],
			events.radio, interrupt_enable_group_one[pmwr_pkg::IEN_RADIO_BIT]);
		nxt_wake_src[2] = wake_sel(wakeup_source_config_ff[pmwr_pkg::WUC_TICK_LSB +: 2],
			events.tick, interrupt_enable_group_one[pmwr_pkg::IEN_TICK_BIT]);
		nxt_wake_src[1] = wake_sel(wakeup_source_config_ff[pmwr_pkg::WUC_PIN_LSB +: 2],
			pin_irq_ff || events.pin, interrupt_enable_group_one[pmwr_pkg::IEN_PIN_BIT]);
		nxt_wake_src[0] = wake_sel(wakeup_source_config_ff[pmwr_pkg::WUC_MISC_LSB +: 2],
			misc_irq_ff, interrupt_enable_group_one[pmwr_pkg::IEN_MISC_BIT]);
	end

	// sticky record of which source woke standby; set beats a clearing write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wake_ff        <= 1'b0;
			wake_status_ff <= 4'h0;
		end
		else
		begin
			wake_ff <= (power_down_mode == pmwr_pkg::PD_STANDBY) && |nxt_wake_src;
			if (wr_access && paddr == pmwr_pkg::ADDR_WAKE_STATUS)
				wake_status_ff <= (power_down_mode == pmwr_pkg::PD_STANDBY) ? nxt_wake_src : 4'h0;
			else if (power_down_mode == pmwr_pkg::PD_STANDBY)
				wake_status_ff <= wake_status_ff | nxt_wake_src;
		end
	end
	assign standby_wakeup = wake_ff;

	AST_WRITE_CLEARS_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
		wr_access && paddr == pmwr_pkg::ADDR_RESET_CAUSE && !cause_capture
			&& !reset_req.generator |=> reset_cause_ff == 3'h0)
		else $error("reset cause not cleared by write");
	AST_CAUSE_ACCUMULATES: assert property (@(posedge pclk) disable iff (!presetn)
		cause_capture && !reset_req.generator |=> (reset_cause_ff & $past(reset_cause_ff))
			== $past(reset_cause_ff))
		else $error("reset cause lost a bit");
	AST_GENERATOR_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
		reset_req.generator |=> reset_cause_ff == 3'h0)
		else $error("generator reset left cause bits");
	AST_ANY_SOURCE_RESETS: assert property (@(posedge pclk) disable iff (!presetn)
		(|reset_req) |=> system_reset_req)
		else $error("reset source did not raise common reset");
	AST_LATCH_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
		operational_mode_control_ff[pmwr_pkg::OPM_LATCH_LOCK_BIT]
			|=> $stable(retention_setup_out))
		else $error("locked retention latch changed");
	AST_WDOG_RET_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		operational_mode_control_ff[pmwr_pkg::OPM_WDOG_RESET_BIT]
			&& power_down_mode == pmwr_pkg::PD_REG_RET |=> watchdog_hold_reset && !watchdog_run)
		else $error("watchdog not held in retention");
	AST_WDOG_DEEP_STOP: assert property (@(posedge pclk) disable iff (!presetn)
		power_down_mode == pmwr_pkg::PD_DEEP |=> !watchdog_run)
		else $error("watchdog ran in deep sleep");
	AST_MODE_UPPER_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		operational_mode_control_ff[7:3] == 5'h0)
		else $error("reserved mode bits set");
	AST_NO_WAKE_OUTSIDE: assert property (@(posedge pclk) disable iff (!presetn)
		power_down_mode != pmwr_pkg::PD_STANDBY |=> !standby_wakeup)
		else $error("wakeup outside standby");
	AST_MISC_RAISE: assert property (@(posedge pclk) disable iff (!presetn)
		events.adc_done |=> miscellaneous_interrupt)
		else $error("misc interrupt missing");
endmodule : pmwr_ctrl
`default_nettype wire

/* pmwr_src_model.sv */
// far-side model: on-chip event sources, wakeup pins and slave chip select
`timescale 1ns/10ps
`default_nettype none
module pmwr_src_model (
	input  wire logic             pclk,
	output var pmwr_pkg::pmwr_events_t ev,
	output var logic [31:0]       pins,
	output var logic              csn
);
	initial
	begin
		ev = '0;
		pins = 32'h0000_0000;
		csn = 1'b1;
	end

	// one-cycle pulse; indices 2..0 are crystal ready, adc done, random ready
	task automatic pulse(input int idx);
		@(posedge pclk);
		ev[idx] <= 1'b1;
		@(posedge pclk);
		ev[idx] <= 1'b0;
	endtask : pulse

	// pins are {port3, port2, port1, port0}; chip select is active low
	task automatic drive(input logic [31:0] p, input logic c);
		@(posedge pclk);
		pins <= p;
		csn <= c;
	endtask : drive
endmodule : pmwr_src_model
`default_nettype wire

/* pmwr_ctrl_tb.sv */
// self-checking bench for the power mode, reset cause and wakeup unit
`timescale 1ns/10ps
`default_nettype none
module pmwr_ctrl_tb;
	typedef struct packed {
		logic [1:0] pk;
		logic       hi;
		logic [2:0] b;
		logic [4:0] ix;
		logic       lv;
		logic       pol;
		logic       ex;
	} pmwr_pcase_t;
	localparam logic [11:0] A_WUC = pmwr_pkg::ADDR_WAKEUP_SOURCE_CONFIG;
	localparam logic [11:0] A_OPM = pmwr_pkg::ADDR_OPERATIONAL_MODE_CTRL;
	localparam logic [11:0] A_RC  = pmwr_pkg::ADDR_RESET_CAUSE;
	localparam logic [11:0] A_EH  = pmwr_pkg::ADDR_PIN_WAKEUP_ENABLE_HIGH;
	localparam logic [11:0] A_EL  = pmwr_pkg::ADDR_PIN_WAKEUP_ENABLE_LOW;
	localparam logic [11:0] A_WS  = pmwr_pkg::ADDR_WAKE_STATUS;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        cause_capture = 1'b0, watchdog_enabled = 1'b0, spi_slave_enable = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [1:0]  package_sel = 2'h0;
	logic [2:0]  power_down_mode = 3'h0;
	logic [7:0]  interrupt_enable_group_one = 8'h00, retention_setup_in = 8'h00;
	pmwr_pkg::pmwr_rst_req_t reset_req = '0;
	pmwr_pkg::pmwr_events_t  events;
	logic [31:0] pins, prdata, rdat;
	logic [7:0]  retention_setup_out;
	logic        slave_chip_select_n, pready, pslverr, system_reset_req, watchdog_hold_reset;
	logic        watchdog_run, pin_wakeup_interrupt, miscellaneous_interrupt, standby_wakeup;
	logic [2:0]  seen;
	int          err_total = 0;
	int          n_compared = 0;

	pmwr_ctrl dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.package_sel, .reset_req, .cause_capture, .power_down_mode, .watchdog_enabled,
		.interrupt_enable_group_one, .events, .port0_pins(pins[7:0]), .port1_pins(pins[15:8]),
		.port2_pins(pins[23:16]), .port3_pins(pins[31:24]), .spi_slave_enable,
		.slave_chip_select_n, .retention_setup_in, .retention_setup_out, .system_reset_req,
		.watchdog_hold_reset, .watchdog_run, .pin_wakeup_interrupt, .miscellaneous_interrupt,
		.standby_wakeup
	);
	pmwr_src_model src (.pclk(pclk), .ev(events), .pins(pins), .csn(slave_chip_select_n));

	always #25 pclk = ~pclk;
	// outputs may be pulses: remember any high level since the last reset
	always @(posedge pclk)
		seen <= !presetn ? 3'h0 : seen | {standby_wakeup, miscellaneous_interrupt, pin_wakeup_interrupt};

	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] seen_v, input logic [31:0] exp_v);
		n_compared++;
		if (seen_v !== exp_v)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp_v, seen_v);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	task automatic rst;
		@(posedge pclk);
		presetn <= 1'b0;
		cyc(8);
		presetn <= 1'b1;
	endtask : rst

	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		// no wait-state count assumed; only the watchdog ends a stuck access
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rdat = prdata;
		chk("pslverr", 32'(pslverr), 32'(a == 12'hFFC));
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdc(input string nm, input logic [11:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk(nm, rdat, 32'(e));
	endtask : rdc

	task automatic t_regs;
		rdc("wucfg", A_WUC, 8'h00);
		rdc("opm", A_OPM, 8'h00);
		rdc("cause", A_RC, 8'h00);
		rdc("en_hi", A_EH, 8'h00);
		rdc("en_lo", A_EL, 8'h00);
		apb(1'b1, A_EH, 8'hA5);
		rdc("en_hi_rw", A_EH, 8'hA5);
		package_sel <= pmwr_pkg::PKG_MID;
		rdc("en_hi_mid", A_EH, 8'h25);
		package_sel <= pmwr_pkg::PKG_SMALL;
		rdc("en_hi_small", A_EH, 8'h00);
		package_sel <= pmwr_pkg::PKG_LARGE;
		apb(1'b1, 12'hFFC, 8'hFF);
		rdc("unmapped", 12'hFFC, 8'h00);
	endtask : t_regs

	task automatic t_latch;
		retention_setup_in <= 8'h5A;
		cyc(3);
		chk("ret_open", 32'(retention_setup_out), 32'h5A);
		apb(1'b1, A_OPM, 8'h02);
		retention_setup_in <= 8'hC3;
		cyc(3);
		chk("ret_lock", 32'(retention_setup_out), 32'h5A);
		rdc("opm_lock", A_OPM, 8'h02);
		apb(1'b1, A_OPM, 8'h00);
		cyc(3);
		chk("ret_reopen", 32'(retention_setup_out), 32'hC3);
	endtask : t_latch

	task automatic t_wdog;
		logic [2:0] ml [5] = '{pmwr_pkg::PD_DEEP, pmwr_pkg::PD_MEM_OFF, pmwr_pkg::PD_MEM_ON,
			pmwr_pkg::PD_REG_RET, pmwr_pkg::PD_STANDBY};
		logic h;
		watchdog_enabled <= 1'b1;
		for (int b = 0; b < 2; b++)
		begin
			apb(1'b1, A_OPM, 8'(b));
			cyc(4);
			for (int i = 0; i < 5; i++)
			begin
				power_down_mode <= ml[i];
				cyc(3);
				h = (b == 1) && (i inside {[1:3]});
				chk("wd_hold", 32'(watchdog_hold_reset), 32'(h));
				chk("wd_run", 32'(watchdog_run), 32'(!h && i != 0));
			end
			power_down_mode <= pmwr_pkg::PD_NONE;
		end
	endtask : t_wdog

	task automatic t_cause;
		logic [7:0] acc;
		acc = 8'h00;
		// generator first, then pin, watchdog, debugger
		for (int i = 0; i < 4; i++)
		begin
			reset_req <= {i == 0, i == 1, i == 2, i == 3};
			cause_capture <= (i > 0);
			cyc(1);
			cause_capture <= 1'b0;
			reset_req <= '0;
			cyc(1);
			chk("sys_rst", 32'(system_reset_req), 32'h1);
			if (i > 0)
				acc[i - 1] = 1'b1;
			if (i > 0)
				rdc("cause_acc", A_RC, acc);
		end
		apb(1'b1, A_RC, 8'h5A);
		rdc("cause_wr", A_RC, 8'h00);
		reset_req <= 4'b0001;
		cause_capture <= 1'b1;
		cyc(1);
		cause_capture <= 1'b0;
		reset_req <= '0;
		rst();
		rdc("cause_gen", A_RC, 8'h00);
	endtask : t_cause

	task automatic t_wake;
		int lsb [4] = '{6, 4, 2, 0};
		int ib [4] = '{1, 5, 3, 4};
		for (int s = 0; s < 4; s++)
			for (int c = 0; c < 4; c++)
				for (int e = 0; e < 3; e++)
				begin
					rst();
					power_down_mode <= (e == 2) ? pmwr_pkg::PD_NONE : pmwr_pkg::PD_STANDBY;
					interrupt_enable_group_one <= (e > 0) ? 8'(1 << ib[s]) : 8'h00;
					apb(1'b1, A_WUC, 8'(c << lsb[s]));
					src.pulse(5 - s);
					cyc(8);
					chk("wake", 32'(seen[2]), 32'(c == 2 && e < 2 || c == 0 && e == 1));
					rdc("wake_stat", A_WS, 8'(32'(c == 2 && e < 2 || c == 0 && e == 1) << (3 - s)));
				end
		for (int k = 0; k < 3; k++)
		begin
			rst();
			src.pulse(k);
			cyc(5);
			chk("misc_irq", 32'(seen[1]), 32'h1);
		end
		power_down_mode <= pmwr_pkg::PD_NONE;
	endtask : t_wake

	task automatic t_pins;
		pmwr_pcase_t tc [15] = '{
			'{0, 0, 7, 23, 1, 0, 1}, '{0, 1, 6, 30, 1, 0, 1}, '{0, 1, 7, 15, 1, 0, 1},
			'{0, 0, 0, 17, 1, 0, 0}, '{1, 0, 7, 7, 1, 0, 1}, '{1, 1, 6, 14, 1, 0, 1},
			'{1, 1, 7, 15, 1, 0, 0}, '{2, 0, 6, 6, 1, 0, 1}, '{2, 0, 7, 7, 1, 0, 0},
			'{0, 0, 6, 22, 0, 1, 1}, '{0, 0, 2, 18, 0, 1, 1}, '{0, 0, 5, 21, 0, 1, 0},
			'{0, 0, 6, 22, 0, 0, 0}, '{1, 1, 4, 12, 0, 1, 1}, '{1, 0, 6, 6, 0, 1, 1}};
		foreach (tc[i])
		begin
			src.drive(32'(tc[i].pol & !tc[i].lv & tc[i].ex) << tc[i].ix, 1'b1);
			rst();
			package_sel <= tc[i].pk;
			apb(1'b1, A_OPM, {5'h00, tc[i].pol, 2'h0});
			apb(1'b1, tc[i].hi ? A_EH : A_EL, 8'(1 << tc[i].b));
			src.drive(32'(tc[i].lv) << tc[i].ix, 1'b1);
			cyc(6);
			chk("pin_wake", 32'(seen[0]), 32'(tc[i].ex));
		end
		for (int e = 0; e < 2; e++)
		begin
			src.drive(32'h0, 1'b1);
			rst();
			spi_slave_enable <= 1'(e);
			cyc(2);
			src.drive(32'h0, 1'b0);
			cyc(6);
			chk("csn_wake", 32'(seen[0]), 32'(e));
		end
	endtask : t_pins

	initial
	begin
		#400000;
		err_total++;
		print_verdict();
	end

	initial
	begin
		rst();
		t_regs();
		t_latch();
		t_wdog();
		t_cause();
		t_wake();
		t_pins();
		print_verdict();
	end
endmodule : pmwr_ctrl_tb
`default_nettype wire
